/* include/sdt_pkg.sv */
package sdt_pkg;
    // Register word offsets (byte addresses, 32-bit words)
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_OUTEN    = 8'h04;
    localparam logic [7:0] ADR_FLAGS    = 8'h08;
    localparam logic [7:0] ADR_LCOUNT   = 8'h0C;
    localparam logic [7:0] ADR_HCOUNT   = 8'h10;
    localparam logic [7:0] ADR_LPERIOD  = 8'h14;
    localparam logic [7:0] ADR_HPERIOD  = 8'h18;
    localparam logic [7:0] ADR_LCMP     = 8'h1C;
    localparam logic [7:0] ADR_HCMP     = 8'h20;
    localparam logic [7:0] ADR_PORTOUT  = 8'h24;

    // Control word fields
    localparam int CTRL_SEL_LSB   = 0;
    localparam int CTRL_SPLIT_BIT = 4;
    localparam int CTRL_HIRES_BIT = 5;

    // Flag word fields
    localparam int FLG_LUNF_BIT   = 0;
    localparam int FLG_HUNF_BIT   = 1;
    localparam int FLG_CMP_LSB    = 4;

    localparam int CNT_W          = 8;
    localparam int NCH            = 4;
    localparam int PIN_W          = 8;
    localparam int SEL_W          = 4;
    localparam int PRE_W          = 10;

    localparam logic [7:0]  CNT_BOTTOM = 8'h00;
    localparam logic [3:0]  SEL_OFF    = 4'h0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Prescaler tap for selections 1..7 (divide 1,2,4,8,64,256,1024)
    localparam logic [PRE_W-1:0] DIV_MASK [0:7] = '{
        10'h000, 10'h000, 10'h001, 10'h003,
        10'h007, 10'h03F, 10'h0FF, 10'h3FF};

    typedef enum logic [1:0] {
        SDT_IDLE = 2'b00,
        SDT_ACK  = 2'b01
    } sdt_bus_t;
endpackage : sdt_pkg

/* sim/sdt_evt_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Event channel source: one pulse on the asked lines after a gap
module sdt_evt_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] fire_i,
    input  wire logic [3:0] gap_i,
    output logic [7:0]      event_o = 8'h00,
    output logic            busy_o = 1'b0
);
    logic [7:0] mask_reg;
    logic [3:0] wait_reg;
    always @(posedge clk_i) begin
        event_o <= 8'h00;
        if (rst_i) begin
            busy_o <= 1'b0;
        end else if (!busy_o) begin
            busy_o   <= fire_i != 8'h00;
            mask_reg <= fire_i;
            wait_reg <= gap_i;
        end else if (wait_reg == 4'h0) begin
            event_o <= mask_reg;
            busy_o  <= 1'b0;
        end else begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule : sdt_evt_model
`default_nettype wire

/* sim/sdt_timer_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module sdt_timer_asserts
    import sdt_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [7:0]       adr_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic [7:0]       event_i,
    input wire logic [NCH-1:0]   cmp_event_o,
    input wire logic             low_unf_event_o,
    input wire logic             high_unf_event_o,
    input wire logic [NCH-1:0]   cmp_dma_req_o,
    input wire logic [PIN_W-1:0] pin_o
);
    logic [7:0] ctl_reg;
    logic [7:0] oen_reg;
    logic [7:0] pout_reg;
    logic       quiet;

    // Shadows of control, enable and port value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_reg  <= 8'h00;
            oen_reg  <= 8'h00;
            pout_reg <= 8'h00;
        end else if (cyc_i && stb_i && we_i && !ack_o) begin
            if (adr_i == ADR_CTRL) ctl_reg <= dat_i[7:0];
            if (adr_i == ADR_OUTEN) oen_reg <= dat_i[7:0];
            if (adr_i == ADR_PORTOUT) pout_reg <= dat_i[7:0];
        end
    end
    assign quiet = !low_unf_event_o && !high_unf_event_o && cmp_event_o == 4'h0;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack is not one pulse after a request");
    property p_rst;
        $fell(rst_i) |-> pin_o == 8'h00 && !ack_o && dat_o == 32'h0000_0000
            && cmp_dma_req_o == 4'h0;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
    property p_flag_set;
        cmp_event_o != 4'h0 |=>
            (cmp_dma_req_o & $past(cmp_event_o)) == $past(cmp_event_o);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("compare match did not set its flag");
    property p_flag_src;
        (cmp_dma_req_o & ~$past(cmp_dma_req_o)) != 4'h0 |->
            (cmp_dma_req_o & ~$past(cmp_dma_req_o) & ~$past(cmp_event_o)) == 4'h0;
    endproperty
    a_flag_src: assert property (p_flag_src)
        else $error("compare flag set without a low match");
    property p_stop;
        ctl_reg[3:0] == SEL_OFF || !ctl_reg[CTRL_SPLIT_BIT] |-> quiet;
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter event while stopped");
    property p_evt;
        ctl_reg[3] && !event_i[ctl_reg[2:0]] |-> quiet;
    endproperty
    a_evt: assert property (p_evt)
        else $error("counter event without an event tick");
    property p_pout;
        oen_reg == 8'h00 && $past(oen_reg) == 8'h00 && $stable(pout_reg)
            |-> pin_o == pout_reg;
    endproperty
    a_pout: assert property (p_pout)
        else $error("pins differ from port value");
    property p_pwm;
        $rose(pin_o[0]) && oen_reg[0] && $past(oen_reg[0], 2) |->
            $past(cmp_event_o[0]) || $past(cmp_event_o[0], 2);
    endproperty
    a_pwm: assert property (p_pwm)
        else $error("pin rose without a compare match");
endmodule : sdt_timer_asserts
`default_nettype wire

/* sim/split_dual_8bit_pwm_timer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module split_dual_8bit_pwm_timer_tb
    import sdt_pkg::*;
;
    typedef struct {string nm; logic [31:0] exp; bit chk;} sdt_note_t;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 0, fire = 0, pin_o, ev;
    logic [3:0]  gap = 0, cmp_ev, dma, sel = 0;
    logic [31:0] wdat = 0, rd_last, rs = 32'h5f33, r, dat_o;
    logic        ack_o, lunf, hunf, hires, busy;
    int          fails = 0, num_checks = 0, n_unf = 0;
    sdt_note_t   notes[$];

    sdt_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .event_i(ev), .cmp_event_o(cmp_ev),
        .low_unf_event_o(lunf), .high_unf_event_o(hunf),
        .cmp_dma_req_o(dma), .pin_o(pin_o), .hires_active_o(hires));
    sdt_evt_model u_evt (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .gap_i(gap), .event_o(ev), .busy_o(busy));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic check(string nm, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, string nm,
                       bit c);
        cyc <= 1'b1;
        stb <= 1'b1;
        sel <= 4'hF;
        we <= w;
        adr <= a;
        wdat <= d;
        if (!w) notes.push_back('{nm, d, c});
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, "", 1'b0);
    endtask : wr

    task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, e, nm, 1'b1);
    endtask : rd

    task automatic evt(logic [7:0] m);
        fire <= m;
        gap <= 4'(xs());
        @(posedge clk_i);
        fire <= 8'h00;
        do @(posedge clk_i); while (busy);
        @(posedge clk_i);
    endtask : evt

    // Bench model of one counter and its waveform bits
    task automatic step(inout logic [7:0] c, input logic [31:0] cm,
                        inout logic [3:0] w);
        if (c == 8'h00) begin
            w = 4'h0;
            c = 8'h04;
        end else begin
            for (int i = 0; i < 4; i++)
                if (c == cm[8*i+:8]) w[i] = 1'b1;
            c = c - 8'h01;
        end
    endtask : step

    // Read results checked in request order
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we && notes.size() > 0) begin
            rd_last = dat_o;
            if (notes[0].chk) check(notes[0].nm, notes[0].exp, dat_o);
            void'(notes.pop_front());
        end
    end

    // Underflow event pulses seen
    always @(posedge clk_i) begin
        if (lunf === 1'b1) n_unf++;
        if (hunf === 1'b1) n_unf++;
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        end_of_test();
    end

    initial begin
        int d;
        logic [7:0] lc, hc;
        logic [3:0] lw, hw;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a <= 'h24; a += 4) rd("reset", 8'(a), 32'h0);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        check("pins", 32'h0, {24'h0, pin_o});
        $display("test reset done");
        r = xs();
        wr(ADR_LPERIOD, r);
        rd("lperiod", ADR_LPERIOD, {24'h0, r[7:0]});
        wr(ADR_HPERIOD, ~r);
        rd("hperiod", ADR_HPERIOD, {24'h0, ~r[7:0]});
        wr(ADR_LCMP, r);
        rd("lcmp", ADR_LCMP, r);
        wr(ADR_HCMP, ~r);
        rd("hcmp", ADR_HCMP, ~r);
        wr(8'h3C, r);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        wr(ADR_PORTOUT, r);
        repeat (2) @(posedge clk_i);
        check("portout", {24'h0, r[7:0]}, {24'h0, pin_o});
        $display("test registers done");
        for (int n = 0; n < 8; n++) begin
            wr(ADR_LCOUNT, 32'h0000_000A);
            wr(ADR_HCOUNT, 32'h0000_0014);
            wr(ADR_CTRL, 32'(24 + n));
            repeat (3) evt(8'h01 << n);
            repeat (2) evt(8'h01 << ((n + 1) % 8));
            rd("lcount", ADR_LCOUNT, 32'h0000_0007);
            rd("hcount", ADR_HCOUNT, 32'h0000_0011);
        end
        wr(ADR_CTRL, 32'h0000_0010);
        evt(8'hFF);
        wr(ADR_CTRL, 32'h0000_0001);
        repeat (20) @(posedge clk_i);
        rd("stopped", ADR_LCOUNT, 32'h0000_0007);
        $display("test events done");
        wr(ADR_CTRL, 32'h0000_0018);
        wr(ADR_LPERIOD, 32'h0000_0004);
        wr(ADR_HPERIOD, 32'h0000_0004);
        wr(ADR_LCMP, 32'hFFFF_0201);
        wr(ADR_HCMP, 32'h0403_0201);
        wr(ADR_LCOUNT, 32'h0000_0000);
        wr(ADR_HCOUNT, 32'h0000_0000);
        evt(8'h01);
        wr(ADR_FLAGS, 32'h0000_00FF);
        wr(ADR_OUTEN, 32'h0000_00FF);
        lc = 8'h04;
        hc = 8'h04;
        lw = 4'h0;
        hw = 4'h0;
        n_unf = 0;
        for (int k = 0; k < 12; k++) begin
            evt(8'h01);
            step(lc, 32'hFFFF_0201, lw);
            step(hc, 32'h0403_0201, hw);
            @(posedge clk_i);
            check("pwm pins", {24'h0, hw, lw}, {24'h0, pin_o});
        end
        check("underflows", 32'h0000_0004, n_unf);
        rd("reload", ADR_LCOUNT, {24'h0, lc});
        rd("flags", ADR_FLAGS, 32'h0000_0033);
        check("dma", 32'h3, {28'h0, dma});
        wr(ADR_FLAGS, 32'h0000_00FF);
        rd("flags clear", ADR_FLAGS, 32'h0000_0000);
        $display("test pwm done");
        for (int s = 1; s < 8; s++) begin
            d = (s < 5) ? (1 << (s - 1)) : (16 << (2 * (s - 4)));
            wr(ADR_LCOUNT, 32'h0000_00FF);
            wr(ADR_CTRL, 32'(16 + s));
            repeat (8 * d) @(posedge clk_i);
            wr(ADR_CTRL, 32'h0000_0010);
            bus(1'b0, ADR_LCOUNT, 32'h0, "", 1'b0);
            check("ticks", 32'h1, {31'h0, rd_last inside {[8'hF3:8'hF7]}});
        end
        $display("test prescaler done");
        wr(ADR_CTRL, 32'h0000_0030);
        repeat (2) @(posedge clk_i);
        check("hires on", 32'h1, {31'h0, hires});
        wr(ADR_CTRL, 32'h0000_0020);
        repeat (2) @(posedge clk_i);
        check("hires off", 32'h0, {31'h0, hires});
        rd("ctrl", ADR_CTRL, 32'h0000_0020);
        $display("test hires done");
        end_of_test();
    end
endmodule : split_dual_8bit_pwm_timer_tb

bind sdt_timer sdt_timer_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .event_i(event_i),
    .cmp_event_o(cmp_event_o), .low_unf_event_o(low_unf_event_o),
    .high_unf_event_o(high_unf_event_o), .cmp_dma_req_o(cmp_dma_req_o),
    .pin_o(pin_o));
`default_nettype wire

/* verilog/sdt_counter.sv */
`timescale 1ns/1ns
`default_nettype none
// One 8-bit down-counter with four compare channels.
module sdt_counter
    import sdt_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Control
    input  wire logic                 tick_i,
    input  wire logic                 wr_i,
    input  wire logic [CNT_W-1:0]     wr_val_i,
    input  wire logic [CNT_W-1:0]     period_i,
    input  wire logic [NCH*CNT_W-1:0] compare_value_i,
    // Status
    output logic [CNT_W-1:0]          count_value_o,
    output logic [NCH-1:0]            waveform_output_o,
    output logic                      underflow_o,
    output logic [NCH-1:0]            match_o
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [NCH-1:0]   wave_reg;
    logic [NCH-1:0]   wave_next;
    logic [NCH-1:0]   match_now;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cmp
            assign match_now[g] =
                count_reg == compare_value_i[g*CNT_W +: CNT_W];
        end
    endgenerate

    always_comb begin
        count_next = count_reg;
        wave_next  = wave_reg;
        if (wr_i) begin
            count_next = wr_val_i;
        end else if (tick_i) begin
            if (count_reg == CNT_BOTTOM) begin
                count_next = period_i;
            end else begin
                count_next = count_reg - 8'h01;
            end
        end
        // set on match, clear at bottom
        if (tick_i) begin
            if (count_reg == CNT_BOTTOM) begin
                wave_next = '0;
            end else begin
                wave_next = wave_reg | match_now;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= CNT_BOTTOM;
            wave_reg  <= '0;
        end else begin
            count_reg <= count_next;
            wave_reg  <= wave_next;
        end
    end

    assign count_value_o     = count_reg;
    assign waveform_output_o = wave_reg;
    assign underflow_o       = tick_i && !wr_i && count_reg == CNT_BOTTOM;
    assign match_o           = tick_i ? match_now : '0;
endmodule : sdt_counter
`default_nettype wire

/* verilog/sdt_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module sdt_timer
    import sdt_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    output logic                  ack_o,
    // Event system
    input  wire logic [7:0]       event_i,
    output logic [NCH-1:0]        cmp_event_o,
    output logic                  low_unf_event_o,
    output logic                  high_unf_event_o,
    output logic [NCH-1:0]        cmp_dma_req_o,
    // Port pins and high-resolution status
    output logic [PIN_W-1:0]      pin_o,
    output logic                  hires_active_o
);
    logic [SEL_W-1:0]     count_clock_select_reg, count_clock_select_next;
    logic                 split_reg, split_next;
    logic                 hires_reg, hires_next;
    logic [NCH-1:0]       low_compare_output_enable_reg, low_en_next;
    logic [NCH-1:0]       high_compare_output_enable_reg, high_en_next;
    logic [CNT_W-1:0]     lper_reg, lper_next;
    logic [CNT_W-1:0]     hper_reg, hper_next;
    logic [NCH*CNT_W-1:0] lcmp_reg, lcmp_next;
    logic [NCH*CNT_W-1:0] hcmp_reg, hcmp_next;
    logic [PIN_W-1:0]     portout_reg, portout_next;
    logic                 lunf_reg, lunf_next;
    logic                 hunf_reg, hunf_next;
    logic [NCH-1:0]       cmpf_reg, cmpf_next;
    logic [PRE_W-1:0]     pre_reg, pre_next;
    logic [31:0]          dat_reg, dat_next;
    sdt_bus_t             bus_reg, bus_next;

    logic                 tick;
    logic                 req;
    logic                 wr;
    logic                 low_counter_wr, high_counter_wr;
    logic [CNT_W-1:0]     low_counter, high_counter;
    logic [NCH-1:0]       lwave, hwave, lmatch;
    logic                 lunf, hunf;

    // Merge byte lanes of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign req = cyc_i && stb_i && bus_reg == SDT_IDLE;
    assign wr  = req && we_i;

    always_comb begin
        pre_next = pre_reg + 10'h001;
        tick     = 1'b0;
        if (count_clock_select_reg == SEL_OFF || !split_reg) begin
            tick = 1'b0;
        end else if (count_clock_select_reg[SEL_W-1]) begin
            tick = event_i[count_clock_select_reg[2:0]];
        end else begin
            tick = (pre_reg & DIV_MASK[count_clock_select_reg[2:0]]) == '0;
        end
    end

    // counters only tick in split mode; count writes load them in any mode
    assign low_counter_wr = wr && adr_i == ADR_LCOUNT && sel_i[0];
    assign high_counter_wr = wr && adr_i == ADR_HCOUNT && sel_i[0];

    sdt_counter u_low (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .tick_i            (tick),
        .wr_i              (low_counter_wr),
        .wr_val_i          (dat_i[CNT_W-1:0]),
        .period_i          (lper_reg),
        .compare_value_i   (lcmp_reg),
        .count_value_o     (low_counter),
        .waveform_output_o (lwave),
        .underflow_o       (lunf),
        .match_o           (lmatch)
    );

    sdt_counter u_high (
        .clk_i             (clk_i),
        .rst_i             (rst_i),
        .tick_i            (tick),
        .wr_i              (high_counter_wr),
        .wr_val_i          (dat_i[CNT_W-1:0]),
        .period_i          (hper_reg),
        .compare_value_i   (hcmp_reg),
        .count_value_o     (high_counter),
        .waveform_output_o (hwave),
        .underflow_o       (hunf),
        .match_o           ()
    );

    always_comb begin
        logic [31:0] w;
        w = RESET_WORD;
        count_clock_select_next = count_clock_select_reg;
        split_next   = split_reg;
        hires_next   = hires_reg;
        low_en_next  = low_compare_output_enable_reg;
        high_en_next = high_compare_output_enable_reg;
        lper_next    = lper_reg;
        hper_next    = hper_reg;
        lcmp_next    = lcmp_reg;
        hcmp_next    = hcmp_reg;
        portout_next = portout_reg;
        dat_next     = dat_reg;
        bus_next     = SDT_IDLE;
        // Clear by writing one; a new event in the same cycle wins
        lunf_next = lunf_reg;
        hunf_next = hunf_reg;
        cmpf_next = cmpf_reg;
        if (wr && adr_i == ADR_FLAGS && sel_i[0]) begin
            lunf_next = lunf_reg & ~dat_i[FLG_LUNF_BIT];
            hunf_next = hunf_reg & ~dat_i[FLG_HUNF_BIT];
            cmpf_next = cmpf_reg & ~dat_i[FLG_CMP_LSB +: NCH];
        end
        lunf_next = lunf_next | lunf;
        hunf_next = hunf_next | hunf;
        cmpf_next = cmpf_next | lmatch;
        if (req) begin
            bus_next = SDT_ACK;
            if (adr_i == ADR_CTRL) begin
                w = merge({26'h0, hires_reg, split_reg,
                           count_clock_select_reg}, dat_i, sel_i);
            end else if (adr_i == ADR_OUTEN) begin
                w = merge({24'h0, high_compare_output_enable_reg,
                           low_compare_output_enable_reg}, dat_i, sel_i);
            end else if (adr_i == ADR_FLAGS) begin
                w = {24'h0, cmpf_reg, 2'b00, hunf_reg, lunf_reg};
            end else if (adr_i == ADR_LCOUNT) begin
                w = {24'h0, low_counter};
            end else if (adr_i == ADR_HCOUNT) begin
                w = {24'h0, high_counter};
            end else if (adr_i == ADR_LPERIOD) begin
                w = merge({24'h0, lper_reg}, dat_i, sel_i);
            end else if (adr_i == ADR_HPERIOD) begin
                w = merge({24'h0, hper_reg}, dat_i, sel_i);
            end else if (adr_i == ADR_LCMP) begin
                w = merge(lcmp_reg, dat_i, sel_i);
            end else if (adr_i == ADR_HCMP) begin
                w = merge(hcmp_reg, dat_i, sel_i);
            end else if (adr_i == ADR_PORTOUT) begin
                w = merge({24'h0, portout_reg}, dat_i, sel_i);
            end else begin
                w = RESET_WORD;
            end
            if (we_i) begin
                if (adr_i == ADR_CTRL) begin
                    count_clock_select_next = w[CTRL_SEL_LSB +: SEL_W];
                    split_next = w[CTRL_SPLIT_BIT];
                    hires_next = w[CTRL_HIRES_BIT];
                end else if (adr_i == ADR_OUTEN) begin
                    low_en_next  = w[NCH-1:0];
                    high_en_next = w[2*NCH-1:NCH];
                end else if (adr_i == ADR_LPERIOD) begin
                    lper_next = w[CNT_W-1:0];
                end else if (adr_i == ADR_HPERIOD) begin
                    hper_next = w[CNT_W-1:0];
                end else if (adr_i == ADR_LCMP) begin
                    lcmp_next = w;
                end else if (adr_i == ADR_HCMP) begin
                    hcmp_next = w;
                end else if (adr_i == ADR_PORTOUT) begin
                    portout_next = w[PIN_W-1:0];
                end
            end else begin
                dat_next = w;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_clock_select_reg         <= SEL_OFF;
            split_reg                      <= 1'b0;
            hires_reg                      <= 1'b0;
            low_compare_output_enable_reg  <= '0;
            high_compare_output_enable_reg <= '0;
            lper_reg                       <= CNT_BOTTOM;
            hper_reg                       <= CNT_BOTTOM;
            lcmp_reg                       <= RESET_WORD;
            hcmp_reg                       <= RESET_WORD;
            portout_reg                    <= '0;
            lunf_reg                       <= 1'b0;
            hunf_reg                       <= 1'b0;
            cmpf_reg                       <= '0;
            pre_reg                        <= '0;
            dat_reg                        <= RESET_WORD;
            bus_reg                        <= SDT_IDLE;
        end else begin
            count_clock_select_reg         <= count_clock_select_next;
            split_reg                      <= split_next;
            hires_reg                      <= hires_next;
            low_compare_output_enable_reg  <= low_en_next;
            high_compare_output_enable_reg <= high_en_next;
            lper_reg                       <= lper_next;
            hper_reg                       <= hper_next;
            lcmp_reg                       <= lcmp_next;
            hcmp_reg                       <= hcmp_next;
            portout_reg                    <= portout_next;
            lunf_reg                       <= lunf_next;
            hunf_reg                       <= hunf_next;
            cmpf_reg                       <= cmpf_next;
            pre_reg                        <= pre_next;
            dat_reg                        <= dat_next;
            bus_reg                        <= bus_next;
        end
    end

    assign ack_o = bus_reg == SDT_ACK;
    assign dat_o = dat_reg;

    // compare events and requests from low counter only; underflow events from both counters
    assign cmp_event_o      = lmatch;
    assign cmp_dma_req_o    = cmpf_reg;
    assign low_unf_event_o  = lunf;
    assign high_unf_event_o = hunf;

    genvar p;
    generate
        for (p = 0; p < NCH; p++) begin : g_pin
            assign pin_o[p] = low_compare_output_enable_reg[p] ?
                              lwave[p] : portout_reg[p];
            assign pin_o[p+NCH] = high_compare_output_enable_reg[p] ?
                                  hwave[p] : portout_reg[p+NCH];
        end
    endgenerate

    assign hires_active_o = hires_reg && split_reg;
endmodule : sdt_timer
`default_nettype wire
